// ===== ccior_pkg.sv
package ccior_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_CONFIG_GUARD = 6'h04;
  localparam logic [5:0] IDX_DIRECT_EXT = 6'h08;
  localparam logic [5:0] IDX_X_EXT = 6'h09;
  localparam logic [5:0] IDX_Y_EXT = 6'h0A;
  localparam logic [5:0] IDX_Z_EXT = 6'h0B;
  localparam logic [5:0] IDX_JUMP_EXT = 6'h0C;
  localparam logic [5:0] IDX_SP_LOW = 6'h0D;
  localparam logic [5:0] IDX_SP_HIGH = 6'h0E;
  localparam logic [5:0] IDX_FLAGS = 6'h0F;

  // Memory sizes of this build, as address widths in bits.
  localparam int DATA_ADDR_W = 17;
  localparam int PROG_ADDR_W = 18;
  localparam int WIDEST_ADDR_W = (DATA_ADDR_W > PROG_ADDR_W) ? DATA_ADDR_W : PROG_ADDR_W;
  localparam int PROG_WORD_ADDR_W = PROG_ADDR_W - 1;

  // Implemented bits of each extension byte; zero bits means the register is absent.
  localparam int DATA_EXT_BITS = (DATA_ADDR_W > 16) ? DATA_ADDR_W - 16 : 0;
  localparam int Z_EXT_BITS = (WIDEST_ADDR_W > 16) ? WIDEST_ADDR_W - 16 : 0;
  localparam int JUMP_EXT_BITS = (PROG_ADDR_W > 17) ? PROG_WORD_ADDR_W - 16 : 0;
  localparam int SP_BITS = (DATA_ADDR_W > 16) ? 16 : DATA_ADDR_W;

  localparam logic [7:0] DATA_EXT_MASK = 8'((32'h1 << DATA_EXT_BITS) - 32'h1);
  localparam logic [7:0] Z_EXT_MASK = 8'((32'h1 << Z_EXT_BITS) - 32'h1);
  localparam logic [7:0] JUMP_EXT_MASK = 8'((32'h1 << JUMP_EXT_BITS) - 32'h1);
  localparam logic [15:0] SP_MASK = 16'((32'h1 << SP_BITS) - 32'h1);

  // Internal SRAM placement; the stack pointer resets to its last byte.
  localparam logic [15:0] SRAM_START = 16'h2000;
  localparam logic [15:0] SRAM_BYTES = 16'h2000;
  localparam logic [15:0] SP_RESET = 16'(SRAM_START + SRAM_BYTES - 16'h0001);

  localparam logic [7:0] EXT_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Flag positions in the flags register.
  localparam int FLAG_I = 7;
  localparam int FLAG_T = 6;
  localparam int FLAG_H = 5;
  localparam int FLAG_S = 4;
  localparam int FLAG_V = 3;
  localparam int FLAG_N = 2;
  localparam int FLAG_Z = 1;
  localparam int FLAG_C = 0;

  // Instructions for which a write to the stack pointer low byte holds off interrupts.
  localparam logic [2:0] SP_GUARD_INSTRS = 3'h4;

endpackage

// ===== ccior_top.sv
// Summary of operation
// - Z extension above Z forms 24-bit data address
// - Z extension tops program load and store addresses
// - Unimplemented Z extension bits read zero
// - Z extension absent for small memories
// - Extended jump and call join jump extension
// - Ordinary call and jump ignore jump extension
// - Jump extension is target top byte, masked
// - Jump extension absent up to 128KB program
// - Stack pointer sixteen bits, resets to SRAM top
// - Low byte write blocks interrupts four instructions
// - Unimplemented stack pointer bits read zero
// - Global enable clear blocks every interrupt
// - Interrupt entry never clears global enable
// - Set and clear instructions drive global enable
// - Register change of enable adds wait
// - Bit store writes T, bit load reads it
// - Half carry from low nibble carry
// - Sign equals negative xor overflow
// - Arithmetic results update V N Z C
// - Flags ordered I T H S V N Z C
//
// Register map, as byte addresses on the bus (four times the index):
//   0x10 configuration guard, inert here and read as zero.
//   0x20 direct extension, 0x24 X extension, 0x28 Y extension.
//   0x2C Z extension, two bits with this memory build.
//   0x30 jump extension, one bit with this memory build.
//   0x34 stack pointer low byte, 0x38 stack pointer high byte.
//   0x3C flags, I T H S V N Z C from bit 7 down to bit 0.
// Every other index, and every address that is not word aligned, reads zero
// and ignores writes. Only byte lane 0 carries data; the upper lanes read zero.
//
// Timing: a bus transfer completes in its first access cycle, except a write
// that flips the global enable, which waits one cycle. Read data is registered.
// The core's strobes take effect at the edge on which they are high, and win
// over a bus write to the same register in the same cycle.
//
// Interrupt gate: interrupts pass only while the global enable is set and no
// stack pointer hold-off is running. A write of the stack pointer low byte
// starts a hold-off of four retired instructions; any other I/O write, from
// the bus or from the core, ends it at once.
//
// Reset values: all extension bytes and the flags are zero, and the stack
// pointer holds the last internal SRAM address.
//
// Address outputs are registered, so they follow the Z pointer and the jump
// select one cycle late.
//
// The implementer's own choice: the APB slave port.
module ccior_top (
  input wire logic pclk, // Bus and CPU clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB write byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error, always low.
  input wire logic [15:0] z_pointer, // Current Z pointer from the register file.
  input wire logic ext_jump_sel, // High for extended jump or call, low for ordinary.
  output logic [23:0] data_indirect_addr, // Extended Z address for data access.
  output logic [23:0] program_access_addr, // Extended Z address for program load or store.
  output logic [23:0] jump_target, // Program target for indirect jump or call.
  input wire logic core_sp_we, // Core writes the stack pointer this cycle.
  input wire logic [15:0] core_sp_wdata, // New stack pointer from push, pop, call.
  output logic [15:0] stack_pointer, // Current stack pointer.
  input wire logic alu_flags_we, // Arithmetic or logic result updates V N Z C.
  input wire logic alu_half_we, // Result also updates the half carry.
  input wire logic alu_half_carry, // Carry out of the low nibble.
  input wire logic alu_overflow, // Two's complement overflow of the result.
  input wire logic alu_negative, // Result sign bit.
  input wire logic alu_zero, // Result is zero.
  input wire logic alu_carry, // Carry or borrow out of the result.
  input wire logic bit_store_to_flag, // Bit store instruction this cycle.
  input wire logic bit_store_value, // Register bit to copy into T.
  input wire logic set_global_irq, // Set-enable instruction this cycle.
  input wire logic clear_global_irq, // Clear-enable instruction this cycle.
  input wire logic instr_retired, // One instruction completed.
  input wire logic core_io_write, // Core writes elsewhere in I/O memory.
  output logic bit_load_flag, // T flag for the bit load instruction.
  output logic [7:0] cpu_flags_out, // Flags register for branch logic.
  output logic irq_allowed // Interrupts may be taken now.
);

  // Software-visible registers and their next values.
  logic [7:0] dext_q, dext_d;
  logic [7:0] xext_q, xext_d;
  logic [7:0] yext_q, yext_d;
  logic [7:0] zext_q, zext_d;
  logic [7:0] jext_q, jext_d;
  logic [15:0] sp_q, sp_d;
  logic [7:0] flags_q, flags_d;

  // Wait state of the bus and the interrupt hold-off count.
  logic wait_q, wait_d;
  logic [2:0] guard_q, guard_d;

  // Registered outputs toward the bus and the core.
  logic [31:0] rdata_q, rdata_d;
  logic [23:0] daddr_q, daddr_d;
  logic [23:0] paddr_q, paddr_d;
  logic [23:0] jaddr_q, jaddr_d;

  // Bus decode.
  logic [5:0] reg_idx;
  logic aligned;
  logic access;
  logic wr_en;
  logic rd_en;
  logic lane0;
  logic [7:0] wbyte;

  // Qualified events.
  logic i_change;
  logic spl_write;
  logic other_io_write;

  // Read multiplexer output.
  logic [7:0] rd_byte;

  assign reg_idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign lane0 = pstrb[0];
  assign wbyte = pwdata[7:0];
  assign access = psel & penable;

  // A write that flips the global enable is stretched by one wait cycle.
  assign i_change = pwrite & aligned & lane0 & (reg_idx == ccior_pkg::IDX_FLAGS)
                    & (wbyte[ccior_pkg::FLAG_I] != flags_q[ccior_pkg::FLAG_I]);
  assign pready = ~(access & i_change & ~wait_q);
  assign pslverr = 1'b0;
  assign wr_en = access & pready & pwrite & aligned & lane0;
  assign rd_en = access & pready & ~pwrite;
  assign spl_write = wr_en & (reg_idx == ccior_pkg::IDX_SP_LOW);
  assign other_io_write = core_io_write | (wr_en & (reg_idx != ccior_pkg::IDX_SP_LOW));

  // The wait flag is set for exactly one cycle; the second access cycle sees it and completes.
  always_comb begin
    wait_d = 1'b0;
    if (access & i_change & ~wait_q) begin
      wait_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // No transfer is pending after reset.
      wait_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
    end
  end

  // Register file: software writes first, then the core's own updates win.
  always_comb begin
    dext_d = dext_q;
    xext_d = xext_q;
    yext_d = yext_q;
    zext_d = zext_q;
    jext_d = jext_q;
    sp_d = sp_q;
    flags_d = flags_q;
    if (wr_en) begin
      // Each extension keeps only the bits that this memory build needs.
      unique case (reg_idx)
        ccior_pkg::IDX_DIRECT_EXT: dext_d = wbyte & ccior_pkg::DATA_EXT_MASK;
        ccior_pkg::IDX_X_EXT: xext_d = wbyte & ccior_pkg::DATA_EXT_MASK;
        ccior_pkg::IDX_Y_EXT: yext_d = wbyte & ccior_pkg::DATA_EXT_MASK;
        ccior_pkg::IDX_Z_EXT: zext_d = wbyte & ccior_pkg::Z_EXT_MASK;
        ccior_pkg::IDX_JUMP_EXT: jext_d = wbyte & ccior_pkg::JUMP_EXT_MASK;
        ccior_pkg::IDX_SP_LOW: sp_d[7:0] = wbyte & ccior_pkg::SP_MASK[7:0];
        ccior_pkg::IDX_SP_HIGH: sp_d[15:8] = wbyte & ccior_pkg::SP_MASK[15:8];
        ccior_pkg::IDX_FLAGS: flags_d = wbyte;
        default: begin
          flags_d = flags_q;
        end
      endcase
    end

    // Push, pop and call move the stack pointer over any bus write.
    if (core_sp_we) begin
      sp_d = core_sp_wdata & ccior_pkg::SP_MASK;
    end

    // Flag updates from the core take the place of a bus write to the flags in the bits that they drive.
    if (alu_flags_we) begin
      flags_d[ccior_pkg::FLAG_V] = alu_overflow;
      flags_d[ccior_pkg::FLAG_N] = alu_negative;
      flags_d[ccior_pkg::FLAG_Z] = alu_zero;
      flags_d[ccior_pkg::FLAG_C] = alu_carry;
    end
    if (alu_half_we) begin
      flags_d[ccior_pkg::FLAG_H] = alu_half_carry;
    end
    if (bit_store_to_flag) begin
      flags_d[ccior_pkg::FLAG_T] = bit_store_value;
    end

    // Interrupt entry has no path here, so the global enable survives it.
    if (set_global_irq) begin
      flags_d[ccior_pkg::FLAG_I] = 1'b1;
    end else if (clear_global_irq) begin
      flags_d[ccior_pkg::FLAG_I] = 1'b0;
    end

    // S follows N and V whatever wrote them, so a bus write to bit 4 is lost.
    flags_d[ccior_pkg::FLAG_S] = flags_d[ccior_pkg::FLAG_N] ^ flags_d[ccior_pkg::FLAG_V];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Every register takes its reset value from the package.
      dext_q <= ccior_pkg::EXT_RESET;
      xext_q <= ccior_pkg::EXT_RESET;
      yext_q <= ccior_pkg::EXT_RESET;
      zext_q <= ccior_pkg::EXT_RESET;
      jext_q <= ccior_pkg::EXT_RESET;
      sp_q <= ccior_pkg::SP_RESET;
      flags_q <= ccior_pkg::FLAGS_RESET;
    end else begin
      dext_q <= dext_d;
      xext_q <= xext_d;
      yext_q <= yext_d;
      zext_q <= zext_d;
      jext_q <= jext_d;
      sp_q <= sp_d;
      flags_q <= flags_d;
    end
  end

  // Interrupt hold-off after a stack pointer low byte write.
  // A load of four counts down on retired instructions; any other I/O write ends it.
  always_comb begin
    guard_d = guard_q;
    if (spl_write) begin
      guard_d = ccior_pkg::SP_GUARD_INSTRS;
    end else if (other_io_write) begin
      guard_d = 3'h0;
    end else if (instr_retired && (guard_q != 3'h0)) begin
      guard_d = 3'(guard_q - 3'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // No hold-off runs after reset.
      guard_q <= 3'h0;
    end else begin
      guard_q <= guard_d;
    end
  end

  // The gate is a plain combination of registers, so it never glitches on a bus access.
  assign irq_allowed = flags_q[ccior_pkg::FLAG_I] & (guard_q == 3'h0);

  // Read data is captured at the completing edge and held until the next read.
  always_comb begin
    rd_byte = 8'h00;
    if (aligned) begin
      // Unimplemented bits are masked again on the way out.
      unique case (reg_idx)
        ccior_pkg::IDX_DIRECT_EXT: rd_byte = dext_q & ccior_pkg::DATA_EXT_MASK;
        ccior_pkg::IDX_X_EXT: rd_byte = xext_q & ccior_pkg::DATA_EXT_MASK;
        ccior_pkg::IDX_Y_EXT: rd_byte = yext_q & ccior_pkg::DATA_EXT_MASK;
        ccior_pkg::IDX_Z_EXT: rd_byte = zext_q & ccior_pkg::Z_EXT_MASK;
        ccior_pkg::IDX_JUMP_EXT: rd_byte = jext_q & ccior_pkg::JUMP_EXT_MASK;
        ccior_pkg::IDX_SP_LOW: rd_byte = sp_q[7:0] & ccior_pkg::SP_MASK[7:0];
        ccior_pkg::IDX_SP_HIGH: rd_byte = sp_q[15:8] & ccior_pkg::SP_MASK[15:8];
        ccior_pkg::IDX_FLAGS: rd_byte = flags_q;
        default: rd_byte = 8'h00;
      endcase
    end

    // Only a completed read updates the held data.
    rdata_d = rdata_q;
    if (rd_en) begin
      rdata_d = {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Read data is zero until the first read completes.
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Registered addresses reflect the pointers of the previous cycle.
  always_comb begin
    // Data and program accesses share the Z extension; only the jump has its own.
    daddr_d = {zext_q & ccior_pkg::Z_EXT_MASK, z_pointer};
    paddr_d = {zext_q & ccior_pkg::Z_EXT_MASK, z_pointer};
    if (ext_jump_sel) begin
      jaddr_d = {jext_q & ccior_pkg::JUMP_EXT_MASK, z_pointer};
    end else begin
      jaddr_d = {8'h00, z_pointer};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Addresses start at zero and follow the inputs from the first edge after reset.
      daddr_q <= 24'h000000;
      paddr_q <= 24'h000000;
      jaddr_q <= 24'h000000;
    end else begin
      daddr_q <= daddr_d;
      paddr_q <= paddr_d;
      jaddr_q <= jaddr_d;
    end
  end

  // Bus side.
  assign prdata = rdata_q;

  // Address generation side.
  assign data_indirect_addr = daddr_q;
  assign program_access_addr = paddr_q;
  assign jump_target = jaddr_q;

  // Execution side.
  assign stack_pointer = sp_q;
  assign cpu_flags_out = flags_q;
  assign bit_load_flag = flags_q[ccior_pkg::FLAG_T];

endmodule

// ===== ccior_assertions.sv
module ccior_assertions (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB strobes.
  input wire logic [31:0] prdata, // APB read data.
  input wire logic pready, // APB ready.
  input wire logic [15:0] z_pointer, // Z pointer.
  input wire logic ext_jump_sel, // Extended jump.
  input wire logic [23:0] data_indirect_addr, // Data address.
  input wire logic [23:0] jump_target, // Jump target.
  input wire logic alu_flags_we, // ALU update.
  input wire logic alu_overflow, // V in.
  input wire logic alu_negative, // N in.
  input wire logic alu_zero, // Z in.
  input wire logic alu_carry, // C in.
  input wire logic bit_store_to_flag, // Bit store.
  input wire logic bit_store_value, // Stored bit.
  input wire logic core_io_write, // Core I/O write.
  input wire logic [7:0] cpu_flags_out, // Flags.
  input wire logic irq_allowed // Interrupt gate.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_read_reserved: assert property (psel && penable && pready && !pwrite && paddr < 8'h20 |=> prdata == 32'h0)
    else $error("reserved read not zero");
  a_sign_xor: assert property (cpu_flags_out[4] == (cpu_flags_out[2] ^ cpu_flags_out[3]))
    else $error("sign flag wrong");
  a_irq_gate: assert property (irq_allowed |-> cpu_flags_out[7])
    else $error("interrupt allowed while disabled");
  a_jump_plain: assert property (presetn && !ext_jump_sel |=> jump_target == {8'h00, $past(z_pointer)})
    else $error("ordinary jump target wrong");
  a_data_addr: assert property (presetn |=> data_indirect_addr[15:0] == $past(z_pointer) && data_indirect_addr[23:18] == 6'h00)
    else $error("data address wrong");
  a_alu_flags: assert property (alu_flags_we |=> cpu_flags_out[3:0] == {$past(alu_overflow), $past(alu_negative), $past(alu_zero), $past(alu_carry)})
    else $error("arithmetic flags wrong");
  a_spl_holdoff: assert property (psel && penable && pready && pwrite && paddr == 8'h34 && pstrb[0] && !core_io_write |=> !irq_allowed)
    else $error("stack write did not block interrupts");
  a_flag_wait: assert property (psel && $rose(penable) && pwrite && paddr == 8'h3C && pstrb[0] && pwdata[7] != cpu_flags_out[7] |-> !pready ##1 pready)
    else $error("enable change wait state wrong");
  a_t_store: assert property (bit_store_to_flag |=> cpu_flags_out[6] == $past(bit_store_value))
    else $error("bit store flag wrong");
endmodule
bind ccior_top ccior_assertions chk (.*);

// ===== ccior_core_model.sv
module ccior_core_model (
  input wire logic pclk, // Clock.
  input wire logic en, // Allows instruction strobes.
  input wire logic [31:0] rnd, // Random stimulus.
  output logic [15:0] z_pointer, // Z pointer.
  output logic ext_jump_sel, // Extended jump.
  output logic core_sp_we, // Stack write.
  output logic [15:0] core_sp_wdata, // Stack value.
  output logic alu_flags_we, // ALU update.
  output logic alu_half_we, // Half carry update.
  output logic alu_half_carry, // Half carry.
  output logic alu_overflow, // Overflow.
  output logic alu_negative, // Negative.
  output logic alu_zero, // Zero.
  output logic alu_carry, // Carry.
  output logic bit_store_to_flag, // Bit store.
  output logic bit_store_value, // Stored bit.
  output logic set_global_irq, // Enable set.
  output logic clear_global_irq, // Enable clear.
  output logic instr_retired, // Instruction done.
  output logic core_io_write // Core I/O write.
);
  logic [31:0] r;
  logic e;
  initial begin
    r = 32'h0;
    e = 1'b0;
  end
  always @(posedge pclk) begin
    r <= rnd;
    e <= en;
  end
  assign z_pointer = r[15:0];
  assign core_sp_wdata = r[31:16];
  assign {ext_jump_sel, alu_half_carry, alu_overflow, alu_negative, alu_zero, alu_carry, bit_store_value} = r[22:16];
  assign {core_sp_we, alu_flags_we, alu_half_we, bit_store_to_flag, set_global_irq, clear_global_irq, instr_retired,
    core_io_write} = e ? (r[31:24] & r[7:0]) : 8'h00;
endmodule

// ===== tb_ccior_top.sv
module tb_ccior_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, en, pready, pslverr, rd_seen, s, bit_load_flag, irq_allowed;
  logic [7:0] paddr, cpu_flags_out;
  logic [31:0] pwdata, prdata, rnd;
  logic [15:0] z_pointer, core_sp_wdata, stack_pointer, zp, e;
  logic ext_jump_sel, core_sp_we, alu_flags_we, alu_half_we, alu_half_carry, alu_overflow, alu_negative, alu_zero;
  logic alu_carry, bit_store_to_flag, bit_store_value, set_global_irq, clear_global_irq, instr_retired, core_io_write;
  logic [23:0] data_indirect_addr, program_access_addr, jump_target;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] q[$];
  localparam logic [7:0] ADR [11] = '{8'h00, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h21};
  localparam logic [7:0] MSK [11] = '{8'h00, 8'h00, ccior_pkg::DATA_EXT_MASK, ccior_pkg::DATA_EXT_MASK,
    ccior_pkg::DATA_EXT_MASK, ccior_pkg::Z_EXT_MASK, ccior_pkg::JUMP_EXT_MASK, ccior_pkg::SP_MASK[7:0],
    ccior_pkg::SP_MASK[15:8], 8'hEF, 8'h00};
  ccior_top uut (.*, .pstrb(4'hF));
  ccior_core_model core (.*);
  always #25 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    q.push_back({a, x});
    apb(1'b0, a, 8'h00);
  endtask
  task rst;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(32'(stack_pointer), 32'(ccior_pkg::SP_RESET), "sp reset");
    check(32'(cpu_flags_out), 32'(ccior_pkg::FLAGS_RESET), "flags reset");
    check(32'({data_indirect_addr, jump_target}), 32'h0, "addr reset");
    check(32'({program_access_addr, bit_load_flag, irq_allowed, pslverr}), 32'h0, "misc reset");
    for (int i = 0; i < 11; i++) begin
      rd(ADR[i], i == 7 ? ccior_pkg::SP_RESET[7:0] : i == 8 ? ccior_pkg::SP_RESET[15:8] : 8'h00);
    end
    $display("reset test done");
  endtask
  always @(posedge pclk) begin
    rnd <= xs(rnd);
    rd_seen <= psel & penable & pready & !pwrite;
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors++;
      conclude();
    end
  end
  always @(negedge pclk) begin
    if (rd_seen) begin
      e = q.pop_front();
      check(prdata, {24'h0, e[7:0]}, $sformatf("reg %h", e[15:8]));
    end
  end
  initial begin
    {psel, penable, pwrite, en, rd_seen} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    rnd = 32'd96338;
    rst();
    for (int i = 0; i < 11; i++) begin
      apb(1'b1, ADR[i], 8'hFF);
      rd(ADR[i], MSK[i]);
    end
    @(negedge pclk);
    check(32'(irq_allowed), 32'h1, "irq gate");
    apb(1'b1, 8'h34, rnd[7:0]);
    @(negedge pclk);
    check(32'(irq_allowed), 32'h0, "irq holdoff");
    apb(1'b1, 8'h24, 8'h00);
    @(negedge pclk);
    check(32'(irq_allowed), 32'h1, "irq holdoff end");
    apb(1'b1, 8'h3C, 8'h08);
    rd(8'h3C, 8'h18);
    @(negedge pclk);
    check(32'(irq_allowed), 32'h0, "irq gate off");
    $display("flag test done");
    repeat (6) begin
      @(posedge pclk);
      s = ext_jump_sel;
      zp = z_pointer;
      @(negedge pclk);
      check(32'(data_indirect_addr), 32'({ccior_pkg::Z_EXT_MASK, zp}), "data addr");
      check(32'(program_access_addr), 32'({ccior_pkg::Z_EXT_MASK, zp}), "program addr");
      check(32'(jump_target), 32'({s ? ccior_pkg::JUMP_EXT_MASK : 8'h00, zp}), "jump target");
    end
    $display("address test done");
    en <= 1'b1;
    repeat (400) @(posedge pclk);
    en <= 1'b0;
    $display("random test done");
    rst();
    conclude();
  end
endmodule
